// ---- core/dac_clk_map.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  DAC clock and sample-input front end and its sample source controller.
  Assumes inclusion by bare name from core/ and tb/ files.
*/
`ifndef DAC_CLK_MAP_SVH
`define DAC_CLK_MAP_SVH

// What this block does
// - PLL mode multiplies reference into conversion clock
// - three-bit reference divider: 1, 2, 4, 8
// - five-bit feedback divider: 1, 2, 4, 8, 16, 32
// - output rate is reference times M over N
// - software picks N above 1 for fast reference
// - below 500MHz software doubles loop, sets halving
// - unused loop: software sets bypass and sleep
// - toggling filter clear resets loop control state
// - sixteen-bit words, one per data clock edge
// - source makes data clock as toggling bit
// - words and sync enter elastic input FIFO
// - sync low: gate off, FIFO ignored, zeros out
// - sync rising edge fires configurable sync event
// - sync bit stored in FIFO with each word
// - software sync select and level replace pin
// - delay loop skews data clock for sampling
// - source keeps data clock stable for lock
// - software sets range field before loop restart
// - restart bit initialises the delay loop
// - lock status bit readable after initialisation
// - software clears restart, then polls lock
// - sync must stay high for data flow

// ----------------------------------------------------------------
// device configuration registers (5-bit address, 8-bit data)
// ----------------------------------------------------------------
`define DEV_STATUS_ADDR   5'h00
`define DEV_SYNC_ADDR     5'h03
`define DEV_PLL_DIV_ADDR  5'h09
`define DEV_DLL_ADDR      5'h0A
`define DEV_PLL_CTL_ADDR  5'h0B
`define PLL_N_F           7:5
`define PLL_M_F           4:0
`define PLL_N_TOP         3'd3
`define PLL_M_TOP         3'd5
`define VCO_HALF_B        0
`define LFC_B             1
`define BYPASS_B          2
`define SLEEP_B           3
`define SW_SEL_B          0
`define SW_LEVEL_B        1
`define FIFO_RESYNC_B     2
`define DIV_RESYNC_B      3
`define DLL_RANGE_F       2:0
`define DLL_RESTART_B     3
`define PLL_DIV_RST       8'h00
`define PLL_CTL_RST       8'h00
`define SYNC_RST          8'h00
`define DLL_RST           8'h08
`define DLL_LOCK_COUNT    2'd3

// ----------------------------------------------------------------
// source controller registers (AHB-Lite, byte addresses)
// ----------------------------------------------------------------
`define SRC_CTRL_ADDR     8'h00
`define SRC_DEVCFG_ADDR   8'h04
`define SRC_STATUS_ADDR   8'h08
`define SRC_DATA_ADDR     8'h0C
`define CTRL_EN_B         0
`define CTRL_SYNC_B       1
`define DEVCFG_WE_B       16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define LINK_PERIOD_NS    80
`define HALF_CYCLES       ((`LINK_PERIOD_NS / 2) / `CLK_PERIOD_NS)

`endif

// ---- core/dac_types_pkg.sv ----
/*
  Shared types of the DAC front end and its source.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dac_types_pkg;
    typedef logic [15:0] sample_t;
    typedef logic [4:0]  cfg_addr_t;
    typedef logic [7:0]  cfg_byte_t;
    typedef struct packed {
        logic    sync;
        sample_t word;
    } fifo_word_s;
endpackage

// ---- core/dac_link_if.sv ----
/*
  Link between the sample source and the DAC front end: DDR sample bus,
  data clock, sync line and a same-clock configuration port.
  Assumes both ends run on the same hclk.
*/
`timescale 1ns/1ps
interface dac_link_if;
    logic                      half_rate_data_clk;
    dac_types_pkg::sample_t    data;
    logic                      tx_sync;
    logic                      cfg_we;
    dac_types_pkg::cfg_addr_t  cfg_addr;
    dac_types_pkg::cfg_byte_t  cfg_wdata;
    dac_types_pkg::cfg_byte_t  cfg_rdata;

    modport device (
        input  half_rate_data_clk, data, tx_sync, cfg_we, cfg_addr, cfg_wdata,
        output cfg_rdata
    );
    modport source (
        output half_rate_data_clk, data, tx_sync, cfg_we, cfg_addr, cfg_wdata,
        input  cfg_rdata
    );
endinterface

// ---- core/edge_sync.sv ----
/*
  Two-flop synchroniser with edge detection on the synchronised value.
  Assumes inputs from outside the hclk domain.
*/
`timescale 1ns/1ps
module edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // asynchronous inputs
    input  wire logic [W-1:0]  d,
    // synchronised value and edges
    output logic      [W-1:0]  q,
    output logic      [W-1:0]  rise,
    output logic      [W-1:0]  fall
);
    logic [W-1:0] meta;
    logic [W-1:0] last;

    // two flops, then a history flop for edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q    <= '0;
            last <= '0;
        end else begin
            meta <= d;
            q    <= meta;
            last <= q;
        end
    end

    // edges look only at the second flop and its history
    assign rise = q & ~last;
    assign fall = ~q & last;
endmodule

// ---- core/dac_frontend_dev.sv ----
/*
  DAC clock and sample-input front end: reference clock multiplier,
  delay loop sampling the DDR sample bus, elastic FIFO and sync gating.
  Assumes the link pins are asynchronous to hclk and that the source
  keeps the data clock steady once configured.
*/
`timescale 1ns/1ps
`include "dac_clk_map.svh"
module dac_frontend_dev #(
    parameter int CNT_W = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // link to the sample source
    dac_link_if.device             link,
    // reference clock pin
    input  wire logic              ref_clk_in,
    // conversion side
    output logic                   conv_tick,
    output dac_types_pkg::sample_t sample_out,
    output logic                   transmit_gate,
    output logic                   sync_event,
    output logic                   pll_lock,
    output logic                   dll_lock
);
    import dac_types_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [7:0] pll_div;
    logic [7:0] pll_ctl;
    logic [7:0] sync_ctl;
    logic [7:0] dll_ctl;
    cfg_byte_t  rd_mux;

    // clamp a divider code to its largest legal power of two
    function automatic logic [2:0] log_sel(input logic [4:0] code, input logic [2:0] top);
        log_sel = (code > {2'b00, top}) ? top : code[2:0];
    endfunction

    // register writes from the link and registered read-back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_div        <= `PLL_DIV_RST;
            pll_ctl        <= `PLL_CTL_RST;
            sync_ctl       <= `SYNC_RST;
            dll_ctl        <= `DLL_RST;
            link.cfg_rdata <= '0;
        end else begin
            link.cfg_rdata <= rd_mux;
            if (link.cfg_we) begin
                unique case (link.cfg_addr)
                    `DEV_PLL_DIV_ADDR: pll_div  <= link.cfg_wdata;
                    `DEV_PLL_CTL_ADDR: pll_ctl  <= link.cfg_wdata;
                    `DEV_SYNC_ADDR:    sync_ctl <= link.cfg_wdata;
                    `DEV_DLL_ADDR:     dll_ctl  <= link.cfg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // read decode; lock bits sit in the status byte
    assign rd_mux = (link.cfg_addr == `DEV_STATUS_ADDR)  ? {6'h00, dll_lock, pll_lock} :
                    (link.cfg_addr == `DEV_PLL_DIV_ADDR) ? pll_div :
                    (link.cfg_addr == `DEV_PLL_CTL_ADDR) ? pll_ctl :
                    (link.cfg_addr == `DEV_SYNC_ADDR)    ? sync_ctl :
                    (link.cfg_addr == `DEV_DLL_ADDR)     ? dll_ctl : 8'h00;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic        ref_q;
    logic        ref_rise;
    logic [17:0] lq;
    logic [17:0] lrise;
    logic [17:0] lfall;

    edge_sync #(.W(1)) u_ref_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (ref_clk_in),
        .q       (ref_q),
        .rise    (ref_rise),
        .fall    ()
    );

    // clock, sync and data share one path so they stay aligned
    edge_sync #(.W(18)) u_link_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({link.half_rate_data_clk, link.tx_sync, link.data}),
        .q       (lq),
        .rise    (lrise),
        .fall    (lfall)
    );

    // ----------------------------------------------------------------
    // reference clock multiplier
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cyc_cnt;
    logic [CNT_W-1:0] ref_period;
    logic [CNT_W-1:0] conv_cnt;
    logic [CNT_W-1:0] conv_p;
    logic [CNT_W-1:0] ref_dlt;
    logic [3:0]       ref_edges;
    logic [3:0]       n_val;
    logic [2:0]       m_log;
    logic             lfc_last;
    logic             lfc_toggle;
    logic             pll_sleep;
    logic             ref_near;
    logic             sync_rise;

    assign n_val      = 4'h1 << log_sel({2'b00, pll_div[`PLL_N_F]}, `PLL_N_TOP);
    assign m_log      = log_sel(pll_div[`PLL_M_F], `PLL_M_TOP);
    assign lfc_toggle = pll_ctl[`LFC_B] ^ lfc_last;
    assign pll_sleep  = pll_ctl[`SLEEP_B];
    assign ref_dlt    = cyc_cnt - ref_period;
    assign ref_near   = (ref_dlt == '0) || (ref_dlt == CNT_W'(1)) || (ref_dlt == '1);
    // conversion period is N reference periods over M, doubled if halving
    assign conv_p = (ref_period >> m_log) << pll_ctl[`VCO_HALF_B];

    // measure N reference periods; lock on two agreeing measurements
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfc_last   <= 1'b0;
            cyc_cnt    <= '0;
            ref_period <= '0;
            ref_edges  <= '0;
            pll_lock   <= 1'b0;
        end else begin
            lfc_last <= pll_ctl[`LFC_B];
            if (lfc_toggle || pll_sleep) begin
                cyc_cnt    <= '0;
                ref_period <= '0;
                ref_edges  <= '0;
                pll_lock   <= 1'b0;
            end else begin
                cyc_cnt <= cyc_cnt + 1'b1;
                if (ref_rise) begin
                    ref_edges <= ref_edges + 1'b1;
                    if (ref_edges >= n_val - 4'h1) begin
                        ref_edges  <= '0;
                        cyc_cnt    <= CNT_W'(1);
                        ref_period <= cyc_cnt;
                        pll_lock   <= ref_near;
                    end
                end
            end
        end
    end

    // conversion tick: multiplied clock, or reference edge in bypass
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_cnt  <= '0;
            conv_tick <= 1'b0;
        end else if (pll_ctl[`BYPASS_B]) begin
            conv_cnt  <= '0;
            conv_tick <= ref_rise;
        end else if (!pll_lock || conv_p == '0 || pll_sleep) begin
            conv_cnt  <= '0;
            conv_tick <= 1'b0;
        end else if (sync_rise && sync_ctl[`DIV_RESYNC_B]) begin
            conv_cnt  <= '0;
            conv_tick <= 1'b0;
        end else if (conv_cnt >= conv_p - 1'b1) begin
            conv_cnt  <= '0;
            conv_tick <= 1'b1;
        end else begin
            conv_cnt  <= conv_cnt + 1'b1;
            conv_tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // delay loop: measure the data clock half period, sample mid-bit
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] hp_cnt;
    logic [CNT_W-1:0] hp_meas;
    logic [CNT_W-1:0] cap_cnt;
    logic [CNT_W-1:0] hp_lo;
    logic [CNT_W-1:0] hp_hi;
    logic [CNT_W-1:0] hp_dlt;
    logic [1:0]       stable;
    logic             cap_arm;
    logic             dclk_edge;
    logic             hp_ok;
    logic             cap_now;

    assign dclk_edge = lrise[17] | lfall[17];
    assign hp_lo     = CNT_W'(1) << dll_ctl[`DLL_RANGE_F];
    assign hp_hi     = CNT_W'(4) << dll_ctl[`DLL_RANGE_F];
    assign hp_dlt    = hp_cnt - hp_meas;
    assign hp_ok     = ((hp_dlt == '0) || (hp_dlt == CNT_W'(1)) || (hp_dlt == '1))
                       && (hp_cnt >= hp_lo) && (hp_cnt < hp_hi);
    assign cap_now   = cap_arm && (cap_cnt == '0) && !dclk_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hp_cnt   <= '0;
            hp_meas  <= '0;
            cap_cnt  <= '0;
            stable   <= '0;
            cap_arm  <= 1'b0;
            dll_lock <= 1'b0;
        end else if (dll_ctl[`DLL_RESTART_B]) begin
            hp_cnt   <= '0;
            hp_meas  <= '0;
            stable   <= '0;
            cap_arm  <= 1'b0;
            dll_lock <= 1'b0;
        end else if (dclk_edge) begin
            hp_cnt  <= CNT_W'(1);
            hp_meas <= hp_cnt;
            cap_cnt <= hp_cnt >> 1;
            cap_arm <= 1'b1;
            if (hp_ok) begin
                stable   <= (stable == `DLL_LOCK_COUNT) ? stable : stable + 2'd1;
                dll_lock <= (stable == `DLL_LOCK_COUNT);
            end else begin
                stable   <= '0;
                dll_lock <= 1'b0;
            end
        end else begin
            if (hp_cnt != '1) begin
                hp_cnt <= hp_cnt + 1'b1;
            end
            if (hp_cnt >= hp_hi) begin
                stable   <= '0;
                dll_lock <= 1'b0;
            end
            if (cap_arm) begin
                cap_arm <= (cap_cnt != '0);
                cap_cnt <= (cap_cnt == '0) ? cap_cnt : cap_cnt - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // elastic input FIFO and sync gating
    // ----------------------------------------------------------------
    fifo_word_s mem [DEPTH];
    fifo_word_s popped;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic        full;
    logic        empty;
    logic        push;
    logic        pop;
    logic        sync_eff;
    logic        sync_prev;
    logic        fifo_flush;

    assign full       = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty      = (wp == rp);
    assign push       = cap_now && dll_lock && !full;
    assign pop        = conv_tick && !empty;
    // software level takes over the pin with no alignment to conversion
    assign sync_eff   = sync_ctl[`SW_SEL_B] ? sync_ctl[`SW_LEVEL_B] : popped.sync;
    assign sync_rise  = sync_eff && !sync_prev;
    assign fifo_flush = sync_rise && sync_ctl[`FIFO_RESYNC_B];

    // word and its sync bit are stored together
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= '{sync: lq[16], word: lq[15:0]};
        end
    end

    // pointers, head word and gated output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp            <= '0;
            rp            <= '0;
            popped        <= '0;
            sync_prev     <= 1'b0;
            sync_event    <= 1'b0;
            sample_out    <= '0;
            transmit_gate <= 1'b0;
        end else begin
            wp         <= wp + (AW + 1)'(push);
            rp         <= fifo_flush ? wp : rp + (AW + 1)'(pop);
            sync_prev  <= sync_eff;
            sync_event <= sync_rise;
            if (pop) begin
                popped <= mem[rp[AW-1:0]];
            end else if (conv_tick) begin
                popped.word <= '0;
            end
            transmit_gate <= sync_eff;
            sample_out    <= sync_eff ? popped.word : '0;
        end
    end
endmodule

// ---- core/dac_source_ctl.sv ----
/*
  Sample source controller: AHB-Lite slave registers, configuration
  forwarding to the DAC front end and the DDR sample sender.
  Assumes a single AHB-Lite master and the front end on the same hclk.
*/
`timescale 1ns/1ps
`include "dac_clk_map.svh"
module dac_source_ctl (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link to the front end
    dac_link_if.source       link
);
    import dac_types_pkg::*;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic [1:0]  ctrl;
    logic [31:0] pair;
    logic        pending;
    logic        active;
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic        accept;
    logic        wr_do;
    logic        take;
    logic        next_pending;
    logic [31:0] rd_mux;
    logic [2:0]  div_cnt;
    logic        half_tick;
    sample_t     hi_word;

    assign accept       = hready && hsel && htrans[1];
    assign wr_do        = active && hreadyout && ph_wr;
    assign next_pending = (wr_do && ph_addr == `SRC_DATA_ADDR) || (pending && !take);
    assign rd_mux = (haddr[7:0] == `SRC_CTRL_ADDR)   ? {30'h0, ctrl} :
                    (haddr[7:0] == `SRC_DEVCFG_ADDR) ? {24'h0, link.cfg_rdata} :
                    (haddr[7:0] == `SRC_STATUS_ADDR) ? {30'h0, pending, ctrl[`CTRL_EN_B]} :
                    (haddr[7:0] == `SRC_DATA_ADDR)   ? pair : 32'h0;

    // address phase capture, stall while a sample pair waits to go out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active    <= 1'b0;
            ph_wr     <= 1'b0;
            ph_addr   <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (accept) begin
                active    <= 1'b1;
                ph_wr     <= hwrite;
                ph_addr   <= haddr[7:0];
                hrdata    <= hwrite ? 32'h0 : rd_mux;
                hreadyout <= !(hwrite && haddr[7:0] == `SRC_DATA_ADDR && next_pending);
            end else if (active && !hreadyout) begin
                hreadyout <= !next_pending;
            end else begin
                active    <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end

    // register writes; device writes pass through as one-cycle strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl           <= '0;
            pair           <= '0;
            pending        <= 1'b0;
            link.cfg_we    <= 1'b0;
            link.cfg_addr  <= '0;
            link.cfg_wdata <= '0;
        end else begin
            pending     <= next_pending;
            link.cfg_we <= 1'b0;
            if (wr_do) begin
                unique case (ph_addr)
                    `SRC_CTRL_ADDR: ctrl <= hwdata[1:0];
                    `SRC_DATA_ADDR: pair <= hwdata;
                    `SRC_DEVCFG_ADDR: begin
                        // divider, halving, bypass, sleep, range and restart
                        // settings are software's to choose
                        link.cfg_addr  <= hwdata[12:8];
                        link.cfg_we    <= hwdata[`DEVCFG_WE_B];
                        link.cfg_wdata <= hwdata[7:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // DDR sender: data clock is a toggling bit beside the samples
    // ----------------------------------------------------------------
    assign half_tick = (div_cnt == 3'(`HALF_CYCLES - 1));
    assign take      = half_tick && ctrl[`CTRL_EN_B] && !link.half_rate_data_clk && pending;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt                 <= '0;
            hi_word                 <= '0;
            link.half_rate_data_clk <= 1'b0;
            link.data               <= '0;
            link.tx_sync            <= 1'b0;
        end else if (!ctrl[`CTRL_EN_B]) begin
            div_cnt                 <= '0;
            link.half_rate_data_clk <= 1'b0;
            link.data               <= '0;
            link.tx_sync            <= 1'b0;
        end else begin
            div_cnt <= half_tick ? 3'd0 : div_cnt + 3'd1;
            if (half_tick) begin
                link.half_rate_data_clk <= !link.half_rate_data_clk;
                if (!link.half_rate_data_clk) begin
                    // sync moves only at a pair boundary, so both halves share it
                    link.tx_sync <= ctrl[`CTRL_SYNC_B];
                    link.data <= pending ? pair[15:0] : '0;
                    hi_word   <= pending ? pair[31:16] : '0;
                end else begin
                    link.data <= hi_word;
                end
            end
        end
    end
endmodule

// ---- tb/dac_link_monitor.sv ----
/* link checker: watches the signals of dac_link_if.
   Assumes both ends run on hclk with hresetn. */
`timescale 1ns/1ps
`include "dac_clk_map.svh"
module dac_link_monitor (
    // clock and reset
    input wire logic                      hclk,
    input wire logic                      hresetn,
    // link signals
    input wire logic                      half_rate_data_clk,
    input wire dac_types_pkg::sample_t    data,
    input wire logic                      tx_sync,
    input wire logic                      cfg_we,
    input wire dac_types_pkg::cfg_addr_t  cfg_addr,
    input wire dac_types_pkg::cfg_byte_t  cfg_wdata,
    input wire dac_types_pkg::cfg_byte_t  cfg_rdata
);
    // data clock alias
    wire dck = half_rate_data_clk;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // config port and readback
    property readback(a);
        cfg_we && cfg_addr == a ##1 !cfg_we |=> cfg_rdata == $past(cfg_wdata, 2);
    endproperty
    AST_WE_PULSE: assert property (cfg_we |=> !cfg_we)
        else $error("config strobe longer than one cycle");
    AST_ADDR_HOLD: assert property ($changed({cfg_addr, cfg_wdata}) |-> cfg_we)
        else $error("config address moved without strobe");
    AST_SYNC_BACK: assert property (readback(`DEV_SYNC_ADDR))
        else $error("sync register readback wrong");
    AST_DIV_BACK: assert property (readback(`DEV_PLL_DIV_ADDR))
        else $error("divider register readback wrong");
    AST_DLL_BACK: assert property (readback(`DEV_DLL_ADDR))
        else $error("delay loop register readback wrong");
    // sample link timing
    AST_CLK_HALF: assert property ($changed(dck) |=> $stable(dck)[*3])
        else $error("data clock half period short");
    AST_DATA_EDGE: assert property ($changed(data) |-> $changed(dck))
        else $error("data moved off a clock edge");
    AST_SYNC_RISE: assert property ($changed(tx_sync) |-> $rose(dck))
        else $error("sync moved off a rising edge");
    // main scenarios
    cover property ($rose(dck));
    cover property ($rose(tx_sync));
    cover property (cfg_we && cfg_addr == `DEV_DLL_ADDR);
endmodule

// ---- tb/dac_clock_sync_frontend_test.sv ----
/* bench: AHB master on the source, front end on the link.
   Assumes core files compiled first, header on include path. */
`timescale 1ns/1ps
`include "dac_clk_map.svh"
module dac_clock_sync_frontend_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ref_clk_in = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic hready, conv_tick, transmit_gate, sync_event, pll_lock, dll_lock, sa, sb, se, nz;
    dac_types_pkg::sample_t sample_out;
    int bad_count, n_checks, cyc, g, i;
    // pll ctl, pll div, expected tick gap
    logic [23:0] tab [5] = '{24'h00_02_04, 24'h00_22_08, 24'h01_02_08, 24'h0C_02_10, 24'h00_65_04};
    dac_link_if link ();
    dac_source_ctl i_dac_source_ctl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hready), .hrdata, .hreadyout(hready), .hresp(),
        .link(link));
    dac_frontend_dev i_dac_frontend_dev (.hclk, .hresetn, .link(link), .ref_clk_in, .conv_tick,
        .sample_out, .transmit_gate, .sync_event, .pll_lock, .dll_lock);
    dac_link_monitor i_dac_link_monitor (.hclk, .hresetn,
        .half_rate_data_clk(link.half_rate_data_clk), .data(link.data),
        .tx_sync(link.tx_sync), .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr),
        .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata));
    // 100 MHz clock, 160 ns reference
    initial forever #5 hclk = ~hclk;
    initial forever #80 ref_clk_in = ~ref_clk_in;
    // output watch and timeout
    always @(posedge hclk) begin
        cyc++;
        if (sample_out === 16'hAAAA) sa <= 1;
        if (sample_out === 16'hBBBB) sb <= 1;
        if (sync_event === 1'b1) se <= 1;
        if (sample_out !== 16'h0) nz <= 1;
        if (cyc == 20000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one AHB single transfer
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task dw(input logic [4:0] a, input logic [7:0] d);
        ahb(1, 8'h04, {15'h0, 1'b1, 3'h0, a, d});
    endtask
    // cycles between two conversion ticks
    task gap;
        g = 0;
        do @(posedge hclk); while (conv_tick !== 1'b1);
        do begin
            @(posedge hclk);
            g++;
        end while (conv_tick !== 1'b1);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        ahb(1, `SRC_CTRL_ADDR, 32'h1);
        dw(`DEV_DLL_ADDR, 8'h01);
        while (dll_lock !== 1'b1) @(posedge hclk);
        dw(`DEV_DLL_ADDR, 8'h09);
        repeat (3) @(posedge hclk);
        chk(dll_lock, 32'h0);
        dw(`DEV_DLL_ADDR, 8'h01);
        while (dll_lock !== 1'b1) @(posedge hclk);
        dw(5'h00, 8'h00);
        ahb(0, `SRC_STATUS_ADDR, 32'h0);
        ahb(0, `SRC_DEVCFG_ADDR, 32'h0);
        chk(rd[1], 32'h1);
        $display("delay loop test done");
        for (i = 0; i < 5; i++) begin
            dw(`DEV_PLL_CTL_ADDR, tab[i][23:16]);
            dw(`DEV_PLL_DIV_ADDR, tab[i][15:8]);
            repeat (400) @(posedge hclk);
            gap();
            gap();
            chk(g, tab[i][7:0]);
        end
        $display("multiplier test done");
        nz = 0;
        repeat (4) ahb(1, `SRC_DATA_ADDR, 32'hBBBBAAAA);
        chk(nz, 32'h0);
        {sa, sb, se} = 3'h0;
        ahb(1, `SRC_CTRL_ADDR, 32'h3);
        repeat (8) ahb(1, `SRC_DATA_ADDR, 32'hBBBBAAAA);
        chk({sa, sb, se, transmit_gate}, 32'hF);
        $display("sample flow test done");
        ahb(1, `SRC_CTRL_ADDR, 32'h1);
        dw(`DEV_SYNC_ADDR, 8'h03);
        repeat (20) @(posedge hclk);
        chk(transmit_gate, 32'h1);
        dw(`DEV_SYNC_ADDR, 8'h02);
        repeat (20) @(posedge hclk);
        chk({transmit_gate, sample_out}, 32'h0);
        dw(`DEV_PLL_CTL_ADDR, 8'h02);
        repeat (3) @(posedge hclk);
        chk(pll_lock, 32'h0);
        $display("software sync test done");
        tally_and_finish();
    end
endmodule
